// file: inc/rtcaf_pkg.sv
// Constants shared by the RTC alarm and event flag block
`default_nettype none
package rtcaf_pkg;
    // Register byte addresses
    localparam logic [31:0] RTCAF_ADDR_TIME = 32'h5000_4110;
    localparam logic [31:0] RTCAF_ADDR_CAL = 32'h5000_4114;
    localparam logic [31:0] RTCAF_ADDR_EN = 32'h5000_4118;
    localparam logic [31:0] RTCAF_ADDR_FLAGS = 32'h5000_411c;
    // Values after reset
    localparam logic [31:0] RTCAF_RST_TIME = 32'h0000_0000;
    localparam logic [31:0] RTCAF_RST_CAL = 32'h0000_0000;
    localparam logic [5:0] RTCAF_RST_EN = 6'h00;
    localparam logic [6:0] RTCAF_RST_FLAGS = 7'h00;
    // Writable bits; reserved bits read as zero
    localparam logic [31:0] RTCAF_MASK_TIME = 32'h7f7f_7fff;
    localparam logic [31:0] RTCAF_MASK_CAL = 32'h0000_3ff8;
    // Time alarm fields
    localparam int RTCAF_PM = 30;
    localparam int RTCAF_HR_HI = 29;
    localparam int RTCAF_HR_LO = 24;
    localparam int RTCAF_MIN_HI = 22;
    localparam int RTCAF_MIN_LO = 16;
    localparam int RTCAF_SEC_HI = 14;
    localparam int RTCAF_SEC_LO = 8;
    localparam int RTCAF_HOS_HI = 7;
    localparam int RTCAF_HOS_LO = 0;
    // Calendar alarm fields
    localparam int RTCAF_DATE_HI = 13;
    localparam int RTCAF_DATE_LO = 8;
    localparam int RTCAF_MON_HI = 7;
    localparam int RTCAF_MON_LO = 3;
    // Enable and flag bit positions
    localparam int RTCAF_B_HOS = 0;
    localparam int RTCAF_B_SEC = 1;
    localparam int RTCAF_B_MIN = 2;
    localparam int RTCAF_B_HOUR = 3;
    localparam int RTCAF_B_DATE = 4;
    localparam int RTCAF_B_MON = 5;
    localparam int RTCAF_B_ALARM = 6;
    localparam int RTCAF_NUM_ROLL = 6;
endpackage : rtcaf_pkg
`default_nettype wire

// file: core/rtcaf_top.sv
// RTC alarm matching and event flags with a Wishbone slave
//
// The Wishbone slave port was chosen for this implementation.
`default_nettype none
// Contract
// RULE1 - Time alarm bit 30 marks afternoon in 12-hour mode
// RULE2 - Select high means 12-hour format, low means 24-hour format
// RULE3 - Alarm hour tens in 29:28, units in 27:24, BCD
// RULE4 - Alarm minutes tens in 22:20, units in 19:16, BCD
// RULE5 - Alarm seconds tens in 14:12, units in 11:8, BCD
// RULE6 - Alarm hundredths tens in 7:4, units in 3:0, BCD
// RULE7 - Calendar alarm date tens in 13:12, units in 11:8
// RULE8 - Calendar alarm month tens at bit 7, units in 6:3
// RULE9 - Enable bit 5 adds month match to the alarm
// RULE10 - Enable bit 4 adds date match to the alarm
// RULE11 - Enable bit 3 adds hour match, with afternoon bit
// RULE12 - Enable bit 2 adds minute match to the alarm
// RULE13 - Enable bit 1 adds second match to the alarm
// RULE14 - Enable bit 0 adds hundredths match to the alarm
// RULE15 - Read-only flag bit 6 records an alarm since reset
// RULE16 - Read-only flag bit 5 records a month rollover
// RULE17 - Read-only flag bit 4 records a date rollover
// RULE18 - Read-only flag bit 3 records an hour rollover
// RULE19 - Read-only flag bit 2 records a minute rollover
// RULE20 - Read-only flag bit 1 records a second rollover
// RULE21 - Read-only flag bit 0 records a hundredths rollover
// RULE22 - Alarm needs all enabled fields matching; none enabled, no alarm
// RULE23 - Alarm fires once when the match first begins
module rtcaf_top
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [31:0] curTime,
    input wire logic [31:0] curCalendar,
    input wire logic twelve_hour_select,
    input wire logic [rtcaf_pkg::RTCAF_NUM_ROLL-1:0] rolloverPulse,
    output logic alarmEvent,
    output logic [6:0] eventFlags
);
    import rtcaf_pkg::*;

    // ****************************************
    // Registers and wires
    // ****************************************
    logic [31:0] alarm_time_setting;
    logic [31:0] alarm_calendar_setting;
    logic [5:0] alarm_field_enables;
    logic prevMatch;
    logic busReq;
    logic busWrite;
    logic selTime;
    logic selCal;
    logic selEn;
    logic selFlags;
    logic [31:0] laneMask;
    logic [31:0] next_rdata;
    logic alarm_afternoon_bit;
    logic [1:0] alarm_hour_tens;
    logic [3:0] alarm_hour_units;
    logic match_month_enable;
    logic match_second_enable;
    logic match_centisecond_enable;
    logic pmMatch;
    logic [5:0] fieldMatch;
    logic matchNow;
    logic alarmHit;

    // ****************************************
    // Bus decode
    // ****************************************
    // New request only while no answer is pending
    assign busReq = clkEn && wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign busWrite = busReq && wb_we_i;
    assign selTime = (wb_adr_i == RTCAF_ADDR_TIME);
    assign selCal = (wb_adr_i == RTCAF_ADDR_CAL);
    assign selEn = (wb_adr_i == RTCAF_ADDR_EN);
    assign selFlags = (wb_adr_i == RTCAF_ADDR_FLAGS);

    // Byte enables widened to a bit mask
    genvar gl;
    generate
        for (gl = 0; gl < 4; gl++)
        begin : g_lane
            assign laneMask[gl*8 +: 8] = {8{wb_sel_i[gl]}};
        end
    endgenerate

    // ****************************************
    // Acknowledge
    // ****************************************
    // One ack per request, dropped the cycle after
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
        end
        else if (clkEn)
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // ****************************************
    // Alarm setting registers
    // ****************************************
    // Time alarm, masked to its writable fields
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarm_time_setting <= RTCAF_RST_TIME;
        end
        else if (busWrite && selTime)
        begin
            alarm_time_setting <= ((alarm_time_setting & ~laneMask)
                | (wb_dat_i & laneMask)) & RTCAF_MASK_TIME; // RULE1 RULE3 RULE4 RULE5 RULE6
        end
    end

    // Calendar alarm: date and month digits
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarm_calendar_setting <= RTCAF_RST_CAL;
        end
        else if (busWrite && selCal)
        begin
            alarm_calendar_setting <= ((alarm_calendar_setting & ~laneMask)
                | (wb_dat_i & laneMask)) & RTCAF_MASK_CAL; // RULE7 RULE8
        end
    end

    // Per-field match enables
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarm_field_enables <= RTCAF_RST_EN;
        end
        else if (busWrite && selEn && wb_sel_i[0])
        begin
            alarm_field_enables <= wb_dat_i[5:0];
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Unmapped addresses read as zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (selTime)
        begin
            next_rdata = alarm_time_setting;
        end
        else if (selCal)
        begin
            next_rdata = alarm_calendar_setting;
        end
        else if (selEn)
        begin
            next_rdata = {26'h000_0000, alarm_field_enables};
        end
        else if (selFlags)
        begin
            next_rdata = {25'h000_0000, eventFlags};
        end
    end

    // Read data registered with the ack
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (busReq && !wb_we_i)
        begin
            wb_dat_o <= next_rdata;
        end
    end

    // ****************************************
    // Field comparison
    // ****************************************
    // Named views of the hour fields and of the month, second and hundredths enable bits
    assign alarm_afternoon_bit = alarm_time_setting[RTCAF_PM];
    assign alarm_hour_tens = alarm_time_setting[RTCAF_HR_HI:RTCAF_HR_HI-1];
    assign alarm_hour_units = alarm_time_setting[RTCAF_HR_LO+3:RTCAF_HR_LO];
    assign match_month_enable = alarm_field_enables[RTCAF_B_MON];
    assign match_second_enable = alarm_field_enables[RTCAF_B_SEC];
    assign match_centisecond_enable = alarm_field_enables[RTCAF_B_HOS];

    // Afternoon bit only counts in 12-hour mode
    assign pmMatch = !twelve_hour_select
        || (curTime[RTCAF_PM] == alarm_afternoon_bit); // RULE2 RULE1

    // Each field passes when disabled or equal
    assign fieldMatch[RTCAF_B_HOS] = !match_centisecond_enable
        || (curTime[RTCAF_HOS_HI:RTCAF_HOS_LO]
        == alarm_time_setting[RTCAF_HOS_HI:RTCAF_HOS_LO]); // RULE14
    assign fieldMatch[RTCAF_B_SEC] = !match_second_enable
        || (curTime[RTCAF_SEC_HI:RTCAF_SEC_LO]
        == alarm_time_setting[RTCAF_SEC_HI:RTCAF_SEC_LO]); // RULE13
    assign fieldMatch[RTCAF_B_MIN] = !alarm_field_enables[RTCAF_B_MIN]
        || (curTime[RTCAF_MIN_HI:RTCAF_MIN_LO]
        == alarm_time_setting[RTCAF_MIN_HI:RTCAF_MIN_LO]); // RULE12
    assign fieldMatch[RTCAF_B_HOUR] = !alarm_field_enables[RTCAF_B_HOUR]
        || (pmMatch && curTime[RTCAF_HR_HI:RTCAF_HR_LO]
        == {alarm_hour_tens, alarm_hour_units}); // RULE11
    assign fieldMatch[RTCAF_B_DATE] = !alarm_field_enables[RTCAF_B_DATE]
        || (curCalendar[RTCAF_DATE_HI:RTCAF_DATE_LO]
        == alarm_calendar_setting[RTCAF_DATE_HI:RTCAF_DATE_LO]); // RULE10
    assign fieldMatch[RTCAF_B_MON] = !match_month_enable
        || (curCalendar[RTCAF_MON_HI:RTCAF_MON_LO]
        == alarm_calendar_setting[RTCAF_MON_HI:RTCAF_MON_LO]); // RULE9

    // All enabled fields at once, and at least one enabled
    assign matchNow = (|alarm_field_enables) && (&fieldMatch); // RULE22

    // Rising edge of the match only
    assign alarmHit = matchNow && !prevMatch; // RULE23

    // ****************************************
    // Alarm event
    // ****************************************
    // Previous match, for edge detection
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prevMatch <= 1'b0;
        end
        else if (clkEn)
        begin
            prevMatch <= matchNow; // RULE23
        end
    end

    // One-cycle alarm pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarmEvent <= 1'b0;
        end
        else if (clkEn)
        begin
            alarmEvent <= alarmHit;
        end
    end

    // ****************************************
    // Event flags
    // ****************************************
    // Rollover flags stick until reset
    genvar gf;
    generate
        for (gf = 0; gf < RTCAF_NUM_ROLL; gf++)
        begin : g_flag
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    eventFlags[gf] <= RTCAF_RST_FLAGS[gf];
                end
                else if (clkEn && rolloverPulse[gf])
                begin
                    eventFlags[gf] <= 1'b1; // RULE16 RULE17 RULE18 RULE19 RULE20 RULE21
                end
            end
        end
    endgenerate

    // Alarm flag sticks until reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            eventFlags[RTCAF_B_ALARM] <= RTCAF_RST_FLAGS[RTCAF_B_ALARM];
        end
        else if (clkEn && alarmHit)
        begin
            eventFlags[RTCAF_B_ALARM] <= 1'b1; // RULE15
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_ack_single: assert property (clkEn && wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_ack_answer: assert property (busReq |=> wb_ack_o)
        else $error("request not answered next cycle");

    a_pm_stored: assert property ( // RULE1
        busWrite && selTime && wb_sel_i[3]
        |=> alarm_time_setting[30] == $past(wb_dat_i[30]))
        else $error("afternoon bit not stored");

    a_hour_stored: assert property ( // RULE3
        busWrite && selTime && wb_sel_i[3]
        |=> alarm_time_setting[29:24] == $past(wb_dat_i[29:24]))
        else $error("hour digits not stored");

    a_minute_stored: assert property ( // RULE4
        busWrite && selTime && wb_sel_i[2]
        |=> alarm_time_setting[23:16] == {1'b0, $past(wb_dat_i[22:16])})
        else $error("minute digits not stored");

    a_cal_stored: assert property ( // RULE7 RULE8
        busWrite && selCal && wb_sel_i[1] && wb_sel_i[0]
        |=> alarm_calendar_setting[13:3] == $past(wb_dat_i[13:3]))
        else $error("date or month digits not stored");

    a_none_quiet: assert property ( // RULE22
        clkEn && alarm_field_enables == 6'h00 |=> !alarmEvent)
        else $error("alarm with no field enabled");

    a_hour_mismatch: assert property ( // RULE11
        clkEn && alarm_field_enables == 6'h08
        && curTime[29:24] != alarm_time_setting[29:24] |=> !alarmEvent)
        else $error("alarm despite hour mismatch");

    a_alarm_once: assert property ( // RULE23
        clkEn && alarmEvent |=> !alarmEvent)
        else $error("alarm repeated while match persists");

    a_alarm_flag: assert property ( // RULE15
        alarmEvent |-> eventFlags[6])
        else $error("alarm pulse without flag");

    a_flag_sticky: assert property ( // RULE15 RULE16 RULE21
        (eventFlags & ~$past(eventFlags)) == 7'h00 || $past(clkEn))
        else $error("flag changed while frozen");

    a_roll_flag: assert property ( // RULE16 RULE17 RULE18 RULE19 RULE20 RULE21
        clkEn && rolloverPulse != 6'h00
        |=> (eventFlags[5:0] & $past(rolloverPulse)) == $past(rolloverPulse))
        else $error("rollover not recorded");

    a_flag_hold: assert property ( // RULE15 RULE21
        ##1 ($past(eventFlags) & ~eventFlags) == 7'h00)
        else $error("event flag cleared without reset");

    c_alarm: cover property (alarmEvent);
    c_roll: cover property (clkEn && rolloverPulse[5]);
    c_time_write: cover property (busWrite && selTime);
    c_flag_read: cover property (busReq && !wb_we_i && selFlags);
endmodule : rtcaf_top
`default_nettype wire

// file: dv/rtcaf_top_tb.sv
// Self-checking bench for the RTC alarm and event flag block
`default_nettype none
module rtcaf_top_tb import rtcaf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals and design
    // ****************************************
    logic clk, rst_n, clkEn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, twelve_hour_select;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, curTime, curCalendar, rdv;
    logic [3:0] wb_sel_i;
    logic [5:0] rolloverPulse;
    logic alarmEvent;
    logic [6:0] eventFlags;
    int nMismatch = 0;
    int samplesChecked = 0;
    // Alarm settings: afternoon 11:45:37.89, date 28, month 12
    localparam logic [31:0] ALM_T = 32'h5145_3789;
    localparam logic [31:0] ALM_C = 32'h0000_2890;
    localparam logic [31:0] TMASK [6] = '{32'hff, 32'h7f00, 32'h7f_0000, 32'h7f00_0000,
        32'h0, 32'h0};
    localparam logic [31:0] CMASK [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h3f00, 32'hf8};
    localparam logic [31:0] ADRS [5] = '{RTCAF_ADDR_TIME, RTCAF_ADDR_CAL, RTCAF_ADDR_EN,
        RTCAF_ADDR_FLAGS, 32'h5000_4120};
    localparam logic [31:0] AFTER1 [5] = '{RTCAF_MASK_TIME, RTCAF_MASK_CAL, 32'h3f, 32'h0, 32'h0};

    rtcaf_top dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .curTime(curTime),
        .curCalendar(curCalendar), .twelve_hour_select(twelve_hour_select),
        .rolloverPulse(rolloverPulse), .alarmEvent(alarmEvent), .eventFlags(eventFlags));

    // ****************************************
    // Clock and watchdog
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Cuts a hang short well past the expected run
    initial
    begin
        repeat (5000) @(posedge clk);
        nMismatch++;
        printVerdict();
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            nMismatch++;
        end
    endtask : chk

    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb_xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hf;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack_o !== 1'b1);
        // Registered ack, seen at the second edge
        chk("ack wait", 32'h2, 32'(n));
        rdv = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_xfer

    task automatic rd_chk(input logic [31:0] adr, input logic [31:0] exp);
        wb_xfer(1'b0, adr, 32'h0);
        chk($sformatf("register %h", adr), exp, rdv);
    endtask : rd_chk

    task automatic set_cur(input logic [31:0] t, input logic [31:0] c, input logic h);
        @(posedge clk);
        curTime <= t;
        curCalendar <= c;
        twelve_hour_select <= h;
    endtask : set_cur

    // One edge on, then the alarm output is looked at
    task automatic step(input logic exp);
        @(posedge clk);
        #1;
        chk("alarm pulse", {31'h0, exp}, {31'h0, alarmEvent});
    endtask : step

    task automatic printVerdict();
        $display("Mismatches %0d, comparisons %0d", nMismatch, samplesChecked);
        if (nMismatch == 0 && samplesChecked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : printVerdict

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        {wb_adr_i, wb_dat_i, wb_sel_i} = 68'h0;
        {curTime, curCalendar} = 64'h0;
        twelve_hour_select = 1'b1;
        rolloverPulse = 6'h00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, writable bits, read-only flags, unmapped place
        for (int k = 0; k < 5; k++)
        begin
            rd_chk(ADRS[k], 32'h0);
            wb_xfer(1'b1, ADRS[k], 32'hffff_ffff);
            rd_chk(ADRS[k], AFTER1[k]);
        end
        wb_xfer(1'b1, RTCAF_ADDR_TIME, ALM_T);
        rd_chk(RTCAF_ADDR_TIME, ALM_T);
        wb_xfer(1'b1, RTCAF_ADDR_CAL, ALM_C);
        rd_chk(RTCAF_ADDR_CAL, ALM_C);
        // No enables: full match never fires
        wb_xfer(1'b1, RTCAF_ADDR_EN, 32'h0);
        set_cur(ALM_T, ALM_C, 1'b1);
        step(1'b0);
        step(1'b0);
        // Each enable alone: only its own field has to match
        for (int i = 0; i < 6; i++)
        begin
            set_cur(32'h0, 32'h0, 1'b1);
            wb_xfer(1'b1, RTCAF_ADDR_EN, 32'h1 << i);
            set_cur(ALM_T & TMASK[i], ALM_C & CMASK[i], 1'b1);
            step(1'b1);
            chk("alarm flag", 32'h1, {31'h0, eventFlags[6]});
            step(1'b0);
            step(1'b0);
        end
        // Two enables: both fields must match together
        set_cur(32'h0, 32'h0, 1'b1);
        wb_xfer(1'b1, RTCAF_ADDR_EN, 32'h0c);
        set_cur(ALM_T & TMASK[3], 32'h0, 1'b1);
        step(1'b0);
        set_cur(ALM_T & 32'h7f7f_0000, 32'h0, 1'b1);
        step(1'b1);
        // Afternoon bit counts in 12-hour mode only
        set_cur(32'h0, 32'h0, 1'b1);
        wb_xfer(1'b1, RTCAF_ADDR_EN, 32'h08);
        set_cur(32'h1100_0000, 32'h0, 1'b1);
        step(1'b0);
        set_cur(32'h1100_0000, 32'h0, 1'b0);
        step(1'b1);
        // Rollover flags collect one by one
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            rolloverPulse <= 6'(1 << i);
            @(posedge clk);
            rolloverPulse <= 6'h00;
            #1;
            chk("flags", {25'h0, 1'b1, 6'((1 << (i + 1)) - 1)}, {25'h0, eventFlags});
        end
        rd_chk(RTCAF_ADDR_FLAGS, 32'h7f);
        // Second reset clears everything
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(RTCAF_ADDR_FLAGS, 32'h0);
        rd_chk(RTCAF_ADDR_EN, 32'h0);
        // Frozen while the clock enable is low
        @(posedge clk);
        clkEn <= 1'b0;
        rolloverPulse <= 6'h01;
        @(posedge clk);
        @(posedge clk);
        rolloverPulse <= 6'h00;
        clkEn <= 1'b1;
        #1;
        chk("frozen flags", 32'h0, {25'h0, eventFlags});
        printVerdict();
    end
endmodule : rtcaf_top_tb
`default_nettype wire
